//--- hdl/srs_slave.sv
// serial register access slave, mode 0, with register memory and fifo port
// assumes sck, mosi and frame_select_n are asynchronous pins and the
// serial clock half period is at least four clk cycles
`timescale 1ns/1ps
// Notes on behaviour
// R1 - slave only, clock polarity 0, phase 0
// R2 - single access: address byte plus one data byte
// R3 - burst: address increments after each data byte
// R4 - fifo address: bytes hit fifo, address held
// R5 - host changes mosi on falling sck edge
// R6 - sample mosi rising, drive miso falling
// R7 - select low starts frame; miso released otherwise
// R8 - first byte: write flag, then 7-bit address
// R9 - data bytes shifted msb first both ways
// R10 - more data bytes follow without new address
// R11 - select rise ends frame; next byte is address
// R12 - write byte returns register's previous value
// R13 - read data ready for first falling edge
module srs_slave
   import srs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       frame_select_n,
   output logic            miso,
   output logic            miso_oe,
   output logic            reg_wr_en,
   output logic [6:0]      reg_wr_addr,
   output logic [7:0]      reg_wr_data,
   output logic            fifo_push,
   output logic [7:0]      fifo_wdata,
   output logic            fifo_pop,
   input  wire logic [7:0] fifo_rdata
);
   srs_regs_t  r_reg;
   srs_regs_t  r_next;
   srs_mem_if  mem_bus ();
   logic       rise;
   logic       fall;
   logic       byte_last;
   logic [7:0] byte_in;
   logic [6:0] addr_step;

   srs_reg_mem #(
      .DEPTH (SRS_DEPTH)
   ) u_mem (
      .clk   (clk),
      .rst_n (rst_n),
      .port  (mem_bus.mem)
   );

   ////////////////////////////////////////////////////////////////////////
   // edges of the synchronised serial clock

   assign rise      = r_reg.sck_sync & ~r_reg.sck_prev;       // R1
   assign fall      = ~r_reg.sck_sync & r_reg.sck_prev;       // R1
   assign byte_last = (r_reg.bit_cnt == SRS_BIT_LAST);
   assign byte_in   = {r_reg.rx[6:0], r_reg.mosi_sync};       // R9
   assign addr_step = r_reg.fifo_mode ? r_reg.addr            // R4
                                      : r_reg.addr + SRS_ADDR_STEP; // R3

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      r_next           = r_reg;
      r_next.sck_meta  = sck;
      r_next.sck_sync  = r_reg.sck_meta;
      r_next.sck_prev  = r_reg.sck_sync;
      r_next.mosi_meta = mosi;
      r_next.mosi_sync = r_reg.mosi_meta;
      r_next.sel_meta  = frame_select_n;
      r_next.sel_sync  = r_reg.sel_meta;
      r_next.rd_en     = 1'b0;
      r_next.wr_en     = 1'b0;
      r_next.push      = 1'b0;
      r_next.pop       = 1'b0;
      r_next.miso_oe   = ~r_reg.sel_sync;                     // R7
      if (r_reg.sel_sync) begin
         // frame over: the next byte is an address again
         r_next.st      = ST_IDLE;                            // R11
         r_next.bit_cnt = SRS_BIT_FIRST;
         r_next.miso    = 1'b0;
      end else begin
         case (r_reg.st)
            ST_IDLE: begin
               r_next.st      = ST_ADDR;                      // R7
               r_next.bit_cnt = SRS_BIT_FIRST;
            end
            ST_ADDR: begin
               if (rise) begin
                  r_next.rx      = byte_in;                   // R6
                  r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
                  if (byte_last) begin
                     r_next.wnr       = byte_in[SRS_WNR_BIT]; // R8
                     r_next.addr      = byte_in[6:0];         // R8
                     r_next.fifo_mode = (byte_in[6:0] == SRS_FIFO_ADDR);
                     r_next.rd_en     = 1'b1;
                     r_next.rd_addr   = byte_in[6:0];
                     r_next.st        = ST_FETCH;
                  end
               end
            end
            ST_FETCH: begin
               // present the byte before the next falling edge
               r_next.st = ST_DATA;                           // R13
               if (r_reg.fifo_mode) begin
                  r_next.tx  = r_reg.wnr ? SRS_BYTE_ZERO : fifo_rdata;
                  r_next.pop = ~r_reg.wnr;                    // R4
               end else begin
                  r_next.tx = mem_bus.rd_data;                // R12
               end
            end
            ST_DATA: begin
               if (rise) begin
                  r_next.rx      = byte_in;                   // R6
                  r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
                  if (byte_last) begin
                     if (r_reg.wnr && r_reg.fifo_mode) begin
                        r_next.push    = 1'b1;                // R4
                        r_next.wr_data = byte_in;
                     end else if (r_reg.wnr) begin
                        r_next.wr_en   = 1'b1;                // R2
                        r_next.wr_addr = r_reg.addr;
                        r_next.wr_data = byte_in;
                     end
                     // further bytes continue the same frame
                     r_next.addr    = addr_step;              // R10
                     r_next.rd_en   = ~r_reg.fifo_mode;
                     r_next.rd_addr = addr_step;
                     r_next.st      = ST_FETCH;
                  end
               end else if (fall) begin
                  r_next.miso = r_reg.tx[7];                  // R6
                  r_next.tx   = {r_reg.tx[6:0], 1'b0};        // R9
               end
            end
            default: begin
               r_next.st = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r_reg          <= '0;
         r_reg.st       <= ST_IDLE;
         // select synchroniser starts at the pin's idle level, no false frame
         r_reg.sel_meta <= 1'b1;
         r_reg.sel_sync <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // memory and pins

   // read address comes from the next state so data land in the fetch cycle
   assign mem_bus.rd_en   = r_next.rd_en;
   assign mem_bus.rd_addr = r_next.rd_addr;
   assign mem_bus.wr_en   = r_reg.wr_en;
   assign mem_bus.wr_addr = r_reg.wr_addr;
   assign mem_bus.wr_data = r_reg.wr_data;

   assign miso        = r_reg.miso;
   assign miso_oe     = r_reg.miso_oe;
   assign reg_wr_en   = r_reg.wr_en;
   assign reg_wr_addr = r_reg.wr_addr;
   assign reg_wr_data = r_reg.wr_data;
   assign fifo_push   = r_reg.push;
   assign fifo_wdata  = r_reg.wr_data;
   assign fifo_pop    = r_reg.pop;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_miso_release: assert property (  // R7
      r_reg.sel_sync |=> !miso_oe)
      else $error("miso driven while select high");
   a_frame_end: assert property (  // R11
      r_reg.sel_sync |=> r_reg.st == ST_IDLE && r_reg.bit_cnt == SRS_BIT_FIRST)
      else $error("frame not ended by select");
   a_rise_sample: assert property (  // R6
      (rise && !r_reg.sel_sync && r_reg.st inside {ST_ADDR, ST_DATA})
      |=> r_reg.rx == {$past(r_reg.rx[6:0]), $past(r_reg.mosi_sync)})
      else $error("mosi not sampled on rising edge");
   a_fall_shift: assert property (  // R9
      (fall && !r_reg.sel_sync && r_reg.st == ST_DATA)
      |=> miso == $past(r_reg.tx[7]))
      else $error("miso not msb first on falling edge");
   a_addr_decode: assert property (  // R8
      (rise && byte_last && !r_reg.sel_sync && r_reg.st == ST_ADDR)
      |=> r_reg.wnr == $past(r_reg.rx[6]) && r_reg.st == ST_FETCH)
      else $error("address byte decoded wrongly");
   a_fetch_time: assert property (  // R13
      (r_reg.st == ST_FETCH && !r_reg.sel_sync)
      |=> r_reg.st == ST_DATA ##1 !fall)
      else $error("data not ready before falling edge");
   a_burst_incr: assert property (  // R3
      (rise && byte_last && !r_reg.sel_sync && r_reg.st == ST_DATA
       && !r_reg.fifo_mode)
      |=> r_reg.addr == $past(r_reg.addr) + SRS_ADDR_STEP)
      else $error("burst address not incremented");
   a_fifo_hold: assert property (  // R4
      (r_reg.fifo_mode && r_reg.st == ST_DATA && !r_reg.sel_sync)
      |=> $stable(r_reg.addr) && !reg_wr_en)
      else $error("fifo address moved or register written");
   a_write_commit: assert property (  // R2
      (rise && byte_last && !r_reg.sel_sync && r_reg.st == ST_DATA
       && r_reg.wnr && !r_reg.fifo_mode)
      |=> reg_wr_en && reg_wr_addr == $past(r_reg.addr))
      else $error("write data byte not committed");
   a_old_value: assert property (  // R12
      (r_reg.st == ST_FETCH && !r_reg.fifo_mode && !r_reg.sel_sync)
      |=> r_reg.tx == $past(mem_bus.rd_data))
      else $error("previous register value not loaded");

   c_reg_write: cover property (reg_wr_en);
   c_burst_read: cover property (
      rise && byte_last && r_reg.st == ST_DATA && !r_reg.sel_sync
      && !r_reg.wnr && !r_reg.fifo_mode);
   c_fifo_write: cover property (fifo_push);
   c_fifo_read: cover property (fifo_pop);
endmodule : srs_slave

//--- hdl/srs_pkg.sv
// constants and types of the serial register access slave
// assumes one 100 MHz clock and a serial clock well below a quarter of it
package srs_pkg;
   localparam int          SRS_ADDR_W   = 7;
   localparam int          SRS_DATA_W   = 8;
   localparam int          SRS_DEPTH    = 128;
   // address at which data bytes go to the packet fifo
   localparam logic [6:0]  SRS_FIFO_ADDR = 7'h00;
   localparam logic [2:0]  SRS_BIT_LAST  = 3'h7;
   localparam logic [2:0]  SRS_BIT_FIRST = 3'h0;
   localparam logic [6:0]  SRS_ADDR_STEP = 7'h01;
   localparam logic [7:0]  SRS_BYTE_ZERO = 8'h00;
   // direction flag position within the address byte
   localparam int          SRS_WNR_BIT   = 7;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_ADDR  = 4'b0010,
      ST_FETCH = 4'b0100,
      ST_DATA  = 4'b1000
   } srs_state_t;

   typedef struct packed {
      srs_state_t st;
      logic       sck_meta;
      logic       sck_sync;
      logic       sck_prev;
      logic       mosi_meta;
      logic       mosi_sync;
      logic       sel_meta;
      logic       sel_sync;
      logic [2:0] bit_cnt;
      logic [7:0] rx;
      logic [7:0] tx;
      logic [6:0] addr;
      logic       wnr;
      logic       fifo_mode;
      logic       miso;
      logic       miso_oe;
      logic       rd_en;
      logic [6:0] rd_addr;
      logic       wr_en;
      logic [6:0] wr_addr;
      logic [7:0] wr_data;
      logic       push;
      logic       pop;
   } srs_regs_t;
endpackage : srs_pkg

//--- hdl/srs_mem_if.sv
// bundle between the serial slave and its register memory
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface srs_mem_if;
   logic       rd_en;
   logic [6:0] rd_addr;
   logic [7:0] rd_data;
   logic       wr_en;
   logic [6:0] wr_addr;
   logic [7:0] wr_data;
   modport ctrl (output rd_en, output rd_addr, input rd_data,
                 output wr_en, output wr_addr, output wr_data);
   modport mem  (input rd_en, input rd_addr, output rd_data,
                 input wr_en, input wr_addr, input wr_data);
endinterface : srs_mem_if

//--- hdl/srs_reg_mem.sv
// configuration register memory, one read and one write port
// assumes read and write are never needed for the same address at once
`timescale 1ns/1ps
module srs_reg_mem
   import srs_pkg::*;
#(
   parameter int DEPTH = SRS_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   srs_mem_if.mem   port
);
   logic [7:0] mem_q [DEPTH];
   logic [7:0] rd_data_reg;

   always_ff @(posedge clk) begin
      if (port.wr_en) begin
         mem_q[port.wr_addr] <= port.wr_data;
      end
   end

   // read data leave through a register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_data_reg <= SRS_BYTE_ZERO;
      end else if (port.rd_en) begin
         rd_data_reg <= mem_q[port.rd_addr];
      end
   end

   assign port.rd_data = rd_data_reg;
endmodule : srs_reg_mem

//--- bench/srs_host.sv
// host master model for the serial register port, mode 0
// assumes clk is the system clock; serial half period is four clk cycles
`timescale 1ns/1ps
module srs_host (
   input  wire logic clk,
   input  wire logic miso,
   output logic      sck,
   output logic      mosi,
   output logic      frame_select_n
);
   logic idle = 1'b1;

   initial begin
      sck = 1'b0;
      mosi = 1'b0;
      frame_select_n = 1'b1;
   end

   // released data line carries a pattern that changes every cycle
   always @(negedge clk) begin
      if (idle) mosi <= ~mosi;
   end

   task automatic half_period;
      repeat (4) @(negedge clk);
   endtask : half_period

   task automatic start;
      @(negedge clk);
      idle = 1'b0;
      frame_select_n = 1'b0;
      half_period();
   endtask : start

   // msb first; data changes on the falling edge, miso taken on the rise
   task automatic xfer(input logic [7:0] b, input int nb,
                       output logic [7:0] r);
      r = 8'h00;
      for (int i = 7; i > 7 - nb; i--) begin
         mosi = b[i];
         half_period();
         sck = 1'b1;
         r[i] = miso;
         half_period();
         sck = 1'b0;
      end
   endtask : xfer

   task automatic stop;
      half_period();
      frame_select_n = 1'b1;
      idle = 1'b1;
   endtask : stop
endmodule : srs_host

//--- bench/srs_slave_tb_top.sv
// self-checking bench of the serial register access slave
// assumes srs_host as the far side and a fifo head modelled here
`timescale 1ns/1ps
module srs_slave_tb_top;
   import srs_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        sck, mosi, frame_select_n, miso, miso_oe;
   logic        reg_wr_en, fifo_push, fifo_pop, chg = 1'b0;
   logic [6:0]  reg_wr_addr;
   logic [7:0]  reg_wr_data, fifo_wdata;
   logic [7:0]  fifo_rdata = 8'h00;
   logic [7:0]  mem[128];
   bit          known[128];
   logic [14:0] wq[$];
   logic [7:0]  pq[$], popq[$];
   int          n_fail = 0, n_checks = 0;
   integer      seed = 32'h27e64e4e;

   always #5 clk = ~clk;

   srs_slave uut (.clk(clk), .rst_n(rst_n), .sck(sck), .mosi(mosi),
      .frame_select_n(frame_select_n), .miso(miso), .miso_oe(miso_oe),
      .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
      .reg_wr_data(reg_wr_data), .fifo_push(fifo_push),
      .fifo_wdata(fifo_wdata), .fifo_pop(fifo_pop),
      .fifo_rdata(fifo_rdata));
   // a released miso line shows the inverse of the slave's miso, which is cleared to 0 then, so it reads 1
   srs_host h (.clk(clk), .miso(miso_oe ? miso : ~miso), .sck(sck),
      .mosi(mosi),
      .frame_select_n(frame_select_n));

   ///////////////////////////////////////////////////////////////////
   // fifo head changes only after a pop has been taken
   always @(negedge clk) begin
      if (chg) fifo_rdata <= 8'($random(seed));
      chg <= (fifo_pop === 1'b1);
      if (fifo_pop === 1'b1) popq.push_back(fifo_rdata);
      if (reg_wr_en === 1'b1) wq.push_back({reg_wr_addr, reg_wr_data});
      if (fifo_push === 1'b1) pq.push_back(fifo_wdata);
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one frame; nb bits of the last data byte (below 8 aborts it)
   task automatic frame(input logic wnr, input logic [6:0] a,
                        input int n, input int nb);
      logic [7:0]  d, r;
      logic [6:0]  p;
      logic [14:0] eq[$];
      logic [7:0]  ep[$];
      p = a;
      wq.delete();
      pq.delete();
      popq.delete();
      h.start();
      h.xfer({wnr, a}, 8, r);
      chk(16'(miso_oe), 16'h0001);
      chk(16'(r), 16'h0000);
      for (int k = 0; k < n; k++) begin
         d = wnr ? 8'($random(seed)) : 8'h00;
         h.xfer(d, (k == n - 1) ? nb : 8, r);
         if (k == n - 1 && nb < 8) break;
         if (p == SRS_FIFO_ADDR) begin
            if (wnr) ep.push_back(d);
            chk(16'(r), wnr ? 16'h0000 : 16'(popq[k]));
         end else begin
            if (known[p]) chk(16'(r), 16'(mem[p]));
            if (wnr) begin
               mem[p] = d;
               known[p] = 1'b1;
               eq.push_back({p, d});
            end
            p = p + SRS_ADDR_STEP;
         end
      end
      h.stop();
      repeat (8) @(negedge clk);
      chk(16'(miso_oe), 16'h0000);
      chk(16'(wq.size()), 16'(eq.size()));
      chk(16'(pq.size()), 16'(ep.size()));
      foreach (eq[i]) chk(16'(wq[i]), 16'(eq[i]));
      foreach (ep[i]) chk(16'(pq[i]), 16'(ep[i]));
   endtask : frame

   ///////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (8) begin
         @(negedge clk);
         chk(16'(miso_oe), 16'h0000);
      end
      for (int i = 0; i < 6; i++) begin
         frame(1'b1, 7'(($random(seed) & 63) + 1), 1, 8);
      end
      frame(1'b1, 7'd124, 4, 8);
      frame(1'b0, 7'd124, 4, 8);
      frame(1'b1, 7'd125, 2, 8);
      frame(1'b1, SRS_FIFO_ADDR, 3, 8);
      frame(1'b0, SRS_FIFO_ADDR, 3, 8);
      frame(1'b1, 7'd124, 1, 5);
      frame(1'b0, 7'd124, 2, 8);
      report_and_stop();
   end

   initial begin
      // the tests need about 2,600 clk cycles
      #200_000;
      n_fail++;
      report_and_stop();
   end
endmodule : srs_slave_tb_top
